// ### hw/async_memory_strobe_sequencer.sv
/*
  Asynchronous memory access sequencer: setup, strobe, hold and turnaround phases
  around chip select, output-enable and write strobes, plus strobe-select mode.
  Assumes sys_clk is the peripheral clock, requests are synchronous to it,
  and the testbench resolves the data bus from ext_data_oe.
*/
`include "async_mem_params.svh"

module async_memory_strobe_sequencer (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`AMS_REQ_ADDR_W-1:0] req_addr,
  input wire logic [`AMS_LANE_W-1:0] req_byte_lane,
  input wire logic [`AMS_DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`AMS_DATA_W-1:0] rsp_rdata,
  output logic busy,
  input wire logic strobe_select_mode,
  input wire logic [`AMS_RS_W-1:0] read_setup_cycles,
  input wire logic [`AMS_RST_W-1:0] read_strobe_cycles,
  input wire logic [`AMS_RH_W-1:0] read_hold_cycles,
  input wire logic [`AMS_RS_W-1:0] write_setup_cycles,
  input wire logic [`AMS_RST_W-1:0] write_strobe_cycles,
  input wire logic [`AMS_RH_W-1:0] write_hold_cycles,
  input wire logic [`AMS_TA_W-1:0] turnaround_cycles,
  output async_mem_pkg::cs_vec_t chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [`AMS_ADDR_W-1:0] ext_addr_bus,
  output logic [`AMS_LANE_W-1:0] byte_lane_addr,
  input wire logic [`AMS_DATA_W-1:0] ext_data_in,
  output logic [`AMS_DATA_W-1:0] ext_data_out,
  output logic ext_data_oe
);
  import async_mem_pkg::*;

  phase_state_t state_reg;
  phase_state_t state_next;
  logic accept;
  logic write_reg;
  logic write_next;
  region_t region_reg;
  region_t region_next;
  cs_vec_t cs_decoded_n;
  logic in_access_next;
  logic cs_on_next;
  logic req_ready_reg;
  logic req_ready_next;
  logic rsp_valid_reg;
  logic [`AMS_DATA_W-1:0] rsp_rdata_reg;
  logic busy_reg;
  cs_vec_t chip_select_n_reg;
  cs_vec_t chip_select_n_next;
  logic read_strobe_n_reg;
  logic write_strobe_n_reg;
  logic [`AMS_ADDR_W-1:0] ext_addr_bus_reg;
  logic [`AMS_LANE_W-1:0] byte_lane_addr_reg;
  logic [`AMS_DATA_W-1:0] ext_data_out_reg;
  logic ext_data_oe_reg;
  logic read_capture;

  phase_if pc ();

  phase_counter u_phase_counter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pc(pc)
  );

  cs_decoder u_cs_decoder (
    .region(region_next),
    .sel_n(cs_decoded_n)
  );

  // Ready is only high when a new access may start on this edge
  assign accept = req_valid && req_ready_reg;
  assign write_next = accept ? req_write : write_reg;
  assign region_next = accept ? req_addr[`AMS_REGION_MSB:`AMS_REGION_LSB] : region_reg;

  // Phase sequence: setup, strobe, hold, turnaround, back to back when requested
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (pc.last) begin
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (pc.last) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (pc.last) begin
          state_next = ST_TURN;
        end
      end
      ST_TURN: begin
        if (pc.last) begin
          state_next = accept ? ST_SETUP : ST_IDLE;
        end
      end
    endcase
  end

  // Each phase loads its count; the counter adds one period to it
  always_comb begin
    pc.load = (state_next != state_reg);
    pc.load_val = `AMS_CNT_ZERO;
    unique case (state_next)
      ST_IDLE: begin
        pc.load_val = `AMS_CNT_ZERO;
      end
      ST_SETUP: begin
        pc.load_val = write_next ? `AMS_CNT_W'(write_setup_cycles) : `AMS_CNT_W'(read_setup_cycles);
      end
      ST_STROBE: begin
        pc.load_val = write_next ? `AMS_CNT_W'(write_strobe_cycles) : `AMS_CNT_W'(read_strobe_cycles);
      end
      ST_HOLD: begin
        pc.load_val = write_next ? `AMS_CNT_W'(write_hold_cycles) : `AMS_CNT_W'(read_hold_cycles);
      end
      ST_TURN: begin
        pc.load_val = `AMS_CNT_W'(turnaround_cycles);
      end
    endcase
  end

  // Ready rises for the last turnaround cycle so accesses chain without a gap cycle
  always_comb begin
    req_ready_next = (state_next == ST_IDLE);
    if (state_next == ST_TURN) begin
      req_ready_next = pc.load ? (turnaround_cycles == `AMS_TA_ZERO) : pc.near_last;
    end
  end

  // Chip select window depends on strobe-select mode
  always_comb begin
    in_access_next = (state_next == ST_SETUP) || (state_next == ST_STROBE) || (state_next == ST_HOLD);
    if (strobe_select_mode) begin
      cs_on_next = (state_next == ST_STROBE);
    end else begin
      cs_on_next = in_access_next;
    end
    chip_select_n_next = cs_on_next ? cs_decoded_n : `AMS_CS_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Access kind and region latched at the start of setup
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      write_reg <= 1'b0;
      region_reg <= `AMS_REGION_RST;
    end else if (accept) begin
      write_reg <= req_write;
      region_reg <= req_addr[`AMS_REGION_MSB:`AMS_REGION_LSB];
    end
  end

  // Address and lanes kept from the start of setup to the end of hold
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ext_addr_bus_reg <= `AMS_ADDR_RST;
      byte_lane_addr_reg <= `AMS_LANE_RST;
    end else if (accept) begin
      ext_addr_bus_reg <= req_addr[`AMS_ADDR_W-1:0];
      byte_lane_addr_reg <= req_byte_lane;
    end
  end

  // Write data kept through hold; also loaded from req_wdata on reads
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ext_data_out_reg <= `AMS_DATA_RST;
    end else if (accept) begin
      ext_data_out_reg <= req_wdata;
    end
  end

  // Pins register the next-state view so they move on the same edge as the phase
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      chip_select_n_reg <= `AMS_CS_IDLE;
    end else begin
      chip_select_n_reg <= chip_select_n_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      read_strobe_n_reg <= 1'b1;
    end else begin
      read_strobe_n_reg <= !((state_next == ST_STROBE) && !write_next);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      write_strobe_n_reg <= 1'b1;
    end else begin
      write_strobe_n_reg <= !((state_next == ST_STROBE) && write_next);
    end
  end

  // Data bus driven from setup through hold of a write only
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ext_data_oe_reg <= 1'b0;
    end else begin
      ext_data_oe_reg <= in_access_next && write_next;
    end
  end

  // Read data sampled on the edge where the read strobe rises
  assign read_capture = (state_reg == ST_STROBE) && pc.last && !write_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= read_capture;
    end
  end

  // Held until the next read completes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rsp_rdata_reg <= `AMS_DATA_RST;
    end else if (read_capture) begin
      rsp_rdata_reg <= ext_data_in;
    end
  end

  // Ready high in idle and in the last turnaround cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      req_ready_reg <= 1'b1;
    end else begin
      req_ready_reg <= req_ready_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_next != ST_IDLE);
    end
  end

  assign req_ready = req_ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign busy = busy_reg;
  assign chip_select_n = chip_select_n_reg;
  assign read_strobe_n = read_strobe_n_reg;
  assign write_strobe_n = write_strobe_n_reg;
  assign ext_addr_bus = ext_addr_bus_reg;
  assign byte_lane_addr = byte_lane_addr_reg;
  assign ext_data_out = ext_data_out_reg;
  assign ext_data_oe = ext_data_oe_reg;
endmodule : async_memory_strobe_sequencer

// ### hw/async_mem_params.svh
/*
  Widths, reset values and phase-count constants for the asynchronous memory strobe sequencer.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef ASYNC_MEM_PARAMS_SVH
`define ASYNC_MEM_PARAMS_SVH

`define AMS_ADDR_W 22
`define AMS_REQ_ADDR_W 24
`define AMS_REGION_LSB 22
`define AMS_REGION_MSB 23
`define AMS_LANE_W 2
`define AMS_DATA_W 16
`define AMS_CS_N 4
`define AMS_REGION_W 2
`define AMS_RS_W 4
`define AMS_RST_W 6
`define AMS_RH_W 3
`define AMS_TA_W 2
`define AMS_CNT_W 6
`define AMS_CNT_ZERO 6'h00
`define AMS_CNT_ONE 6'h01
`define AMS_TA_ZERO 2'h0
`define AMS_CS_IDLE 4'hf
`define AMS_ADDR_RST 22'h000000
`define AMS_LANE_RST 2'h0
`define AMS_DATA_RST 16'h0000
`define AMS_REGION_RST 2'h0
`define AMS_PERIOD_NS 20

`endif

// ### hw/async_mem_pkg.sv
/*
  Types shared by the sequencer and its helpers.
  Assumes the params header is on the include path.
*/
`include "async_mem_params.svh"

package async_mem_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_HOLD   = 5'b01000,
    ST_TURN   = 5'b10000
  } phase_state_t;

  typedef logic [`AMS_CNT_W-1:0] phase_cnt_t;
  typedef logic [`AMS_REGION_W-1:0] region_t;
  typedef logic [`AMS_CS_N-1:0] cs_vec_t;
endpackage : async_mem_pkg

// ### hw/phase_if.sv
/*
  Carrier between the sequencer and its phase counter.
  Assumes the counter and the sequencer share sys_clk.
*/
`include "async_mem_params.svh"

interface phase_if;
  import async_mem_pkg::*;
  logic load;
  phase_cnt_t load_val;
  logic last;
  logic near_last;

  modport ctl (output load, output load_val, input last, input near_last);
  modport cnt (input load, input load_val, output last, output near_last);
endinterface : phase_if

// ### hw/phase_counter.sv
/*
  Down counter for one access phase; a phase lasts load_val plus one cycle.
  Assumes load is raised in the cycle before a phase begins.
*/
`include "async_mem_params.svh"

module phase_counter (
  input wire logic sys_clk,
  input wire logic rst_b,
  phase_if.cnt pc
);
  import async_mem_pkg::*;

  phase_cnt_t cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_reg <= `AMS_CNT_ZERO;
    end else if (pc.load) begin
      cnt_reg <= pc.load_val;
    end else if (cnt_reg != `AMS_CNT_ZERO) begin
      cnt_reg <= cnt_reg - `AMS_CNT_ONE;
    end
  end

  assign pc.last = (cnt_reg == `AMS_CNT_ZERO);
  assign pc.near_last = (cnt_reg == `AMS_CNT_ONE);
endmodule : phase_counter

// ### hw/cs_decoder.sv
/*
  Region to active-low chip select decode, one line low per region.
  Assumes the caller registers the result.
*/
`include "async_mem_params.svh"

module cs_decoder (
  input wire async_mem_pkg::region_t region,
  output async_mem_pkg::cs_vec_t sel_n
);
  import async_mem_pkg::*;

  genvar i;
  generate
    for (i = 0; i < `AMS_CS_N; i++) begin : g_cs
      assign sel_n[i] = (region != region_t'(i));
    end
  endgenerate
endmodule : cs_decoder

// ### tb/async_sram_model.sv
/*
  Behavioural asynchronous memory on the far side of the sequencer.
  Assumes it is the only other party on the data bus.
*/
module async_sram_model (
  input wire logic sys_clk,
  input wire async_mem_pkg::cs_vec_t chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [21:0] ext_addr_bus,
  input wire logic [15:0] ext_data_out,
  input wire logic ext_data_oe,
  output logic [15:0] ext_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [4];
  logic [15:0] last = 16'h0000;
  wire logic sel = chip_select_n != 4'hf;
  always_comb begin
    if (ext_data_oe)
      ext_data_in = ext_data_out;
    else if (sel && !read_strobe_n)
      ext_data_in = mem[ext_addr_bus[1:0]];
    else
      ext_data_in = ~last;
  end
  always @(posedge sys_clk) begin
    last <= ext_data_in;
    if (sel && !write_strobe_n)
      mem[ext_addr_bus[1:0]] <= ext_data_out;
  end
endmodule : async_sram_model

// ### tb/ams_seq_asserts.sv
/*
  Port checker for the strobe sequencer.
  Assumes it is bound to the top module.
*/
`include "async_mem_params.svh"
module ams_seq_asserts (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic strobe_select_mode,
  input wire logic [`AMS_RS_W-1:0] read_setup_cycles,
  input wire logic [`AMS_RST_W-1:0] read_strobe_cycles,
  input wire logic [`AMS_RH_W-1:0] read_hold_cycles,
  input wire logic [`AMS_RS_W-1:0] write_setup_cycles,
  input wire logic [`AMS_RST_W-1:0] write_strobe_cycles,
  input wire logic [`AMS_RH_W-1:0] write_hold_cycles,
  input wire logic [`AMS_TA_W-1:0] turnaround_cycles,
  input wire async_mem_pkg::cs_vec_t chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [`AMS_ADDR_W-1:0] ext_addr_bus,
  input wire logic [`AMS_LANE_W-1:0] byte_lane_addr,
  input wire logic [`AMS_DATA_W-1:0] ext_data_out,
  input wire logic ext_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import async_mem_pkg::*;
  logic [6:0] cs_cnt, str_cnt, hold_cnt, idle_cnt;
  wire logic idle = chip_select_n == 4'hf;
  wire logic str = !(read_strobe_n && write_strobe_n);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cs_cnt <= 7'h00;
      str_cnt <= 7'h00;
      hold_cnt <= 7'h00;
      idle_cnt <= 7'h7f;
    end else begin
      cs_cnt <= idle ? 7'h00 : cs_cnt + 7'h01;
      str_cnt <= str ? str_cnt + 7'h01 : 7'h00;
      hold_cnt <= (idle || str) ? 7'h00 : hold_cnt + 7'h01;
      idle_cnt <= !idle ? 7'h00 : idle_cnt + 7'(idle_cnt != 7'h7f);
    end
  end
  cs_onehot_a: assert property ($countones(~chip_select_n) <= 1) else $error("two chip selects low");
  setup_len_a: assert property (
    $fell(read_strobe_n && write_strobe_n) && !strobe_select_mode
    |-> cs_cnt == 7'(read_strobe_n ? write_setup_cycles : read_setup_cycles) + 7'h01) else $error("setup length");
  select_fall_a: assert property (
    $fell(read_strobe_n && write_strobe_n) && strobe_select_mode |-> $past(idle) && !idle) else $error("select skew");
  strobe_len_a: assert property (
    $rose(read_strobe_n && write_strobe_n)
    |-> str_cnt == 7'($past(read_strobe_n) ? write_strobe_cycles : read_strobe_cycles) + 7'h01) else $error("strobe len");
  hold_len_a: assert property (
    idle && !$past(idle) && !strobe_select_mode
    |-> hold_cnt == 7'($past(ext_data_oe) ? write_hold_cycles : read_hold_cycles) + 7'h01) else $error("hold length");
  turn_gap_a: assert property (
    !idle && $past(idle) |-> idle_cnt > 7'(turnaround_cycles)) else $error("turnaround short");
  bus_stable_a: assert property (
    !idle && !$past(idle) |-> $stable(ext_addr_bus) && $stable(byte_lane_addr) && $stable({ext_data_oe, ext_data_out}))
    else $error("bus moved in access");
  data_dir_a: assert property (str |-> ext_data_oe == !write_strobe_n) else $error("data direction");
endmodule : ams_seq_asserts

bind async_memory_strobe_sequencer ams_seq_asserts chk (.*);

// ### tb/async_memory_strobe_sequencer_bench.sv
/*
  Scenario bench for the strobe sequencer with a memory model.
  Assumes design, model and checker files are compiled first.
*/
module async_memory_strobe_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import async_mem_pkg::*;
  logic sys_clk = 0, rst_b = 0, req_valid = 0, req_write = 0, strobe_select_mode = 0;
  logic [23:0] req_addr = 24'h000000;
  logic [1:0] req_byte_lane = 2'h0, turnaround_cycles = 2'h0, byte_lane_addr;
  logic [15:0] req_wdata = 16'h0000, rsp_rdata, ext_data_in, ext_data_out;
  logic [3:0] read_setup_cycles = 4'h0, write_setup_cycles = 4'h0;
  logic [5:0] read_strobe_cycles = 6'h00, write_strobe_cycles = 6'h00;
  logic [2:0] read_hold_cycles = 3'h0, write_hold_cycles = 3'h0;
  logic req_ready, rsp_valid, busy, read_strobe_n, write_strobe_n, ext_data_oe;
  logic [21:0] ext_addr_bus;
  logic [6:0] per, last_len;
  cs_vec_t chip_select_n, cs_seen, prev_cs = 4'hf;
  int n_fail = 0, n_checks = 0, cyc = 0, fall_at = 0;
  async_memory_strobe_sequencer uut (.*);
  async_sram_model mem_model (.*);
  initial forever #10 sys_clk = ~sys_clk;
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Cycle count from one chip select fall to the next
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    prev_cs <= chip_select_n;
    if (prev_cs == 4'hf && chip_select_n != 4'hf) begin
      per <= 7'(cyc - fall_at);
      fall_at <= cyc;
      cs_seen <= chip_select_n;
    end
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic cfg(logic [3:0] rs, logic [5:0] rt, logic [2:0] rh, logic [3:0] ws, logic [5:0] wt,
                     logic [2:0] wh, logic [1:0] ta, logic m);
    repeat (20) @(posedge sys_clk);
    check("busy idle", {15'h0000, busy}, 16'h0000);
    read_setup_cycles <= rs;
    read_strobe_cycles <= rt;
    read_hold_cycles <= rh;
    write_setup_cycles <= ws;
    write_strobe_cycles <= wt;
    write_hold_cycles <= wh;
    turnaround_cycles <= ta;
    strobe_select_mode <= m;
    // Let the new counts settle before the next access reads them
    @(posedge sys_clk);
  endtask : cfg
  task automatic acc(logic w, logic [1:0] rg, logic [15:0] d, logic chk);
    logic [3:0] s;
    logic got;
    s = w ? write_setup_cycles : read_setup_cycles;
    got = w;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= {rg, 20'h00000, rg};
    req_byte_lane <= rg;
    req_wdata <= d;
    do @(posedge sys_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // Chip select falls only with the strobe, after setup, in strobe-select mode
    for (int k = 0; k < 3 + (strobe_select_mode ? int'(s) : 0) || !got; k++) begin
      @(posedge sys_clk);
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        check("rsp_rdata", rsp_rdata, d);
      end
    end
    check("chip_select_n", {12'h000, cs_seen}, {12'h000, 4'hf ^ (4'h1 << rg)});
    check("byte_lane_addr", {14'h0000, byte_lane_addr}, {14'h0000, rg});
    check("ext_addr_bus", {ext_addr_bus[21:8], ext_addr_bus[1:0]}, {14'h0000, rg});
    check("busy", {15'h0000, busy}, 16'h0001);
    if (chk) check("access period", {9'h000, per}, {9'h000, last_len});
    last_len = 7'(s) + 7'(turnaround_cycles) + 7'h04 + (w ? 7'(write_strobe_cycles) + 7'(write_hold_cycles)
                                                          : 7'(read_strobe_cycles) + 7'(read_hold_cycles));
  endtask : acc
  task automatic s_normal();
    cfg(4'h2, 6'h03, 3'h1, 4'h1, 6'h01, 3'h2, 2'h2, 1'b0);
    for (int r = 0; r < 4; r++)
      acc(1'b1, 2'(r), 16'h5a30 + 16'(r), r > 0);
    for (int r = 0; r < 4; r++)
      acc(1'b0, 2'(r), 16'h5a30 + 16'(r), 1'b1);
  endtask : s_normal
  task automatic s_strobe_sel();
    cfg(4'h1, 6'h00, 3'h1, 4'h1, 6'h00, 3'h1, 2'h0, 1'b1);
    acc(1'b1, 2'h2, 16'hc3c3, 1'b0);
    acc(1'b0, 2'h2, 16'hc3c3, 1'b1);
    acc(1'b1, 2'h3, 16'h0f0f, 1'b1);
    acc(1'b0, 2'h3, 16'h0f0f, 1'b1);
  endtask : s_strobe_sel
  task automatic s_max();
    cfg(4'hf, 6'h3f, 3'h7, 4'hf, 6'h3f, 3'h7, 2'h3, 1'b0);
    acc(1'b1, 2'h1, 16'hffff, 1'b0);
    acc(1'b0, 2'h1, 16'hffff, 1'b1);
  endtask : s_max
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    s_normal();
    s_strobe_sel();
    s_max();
    final_report();
  end
endmodule : async_memory_strobe_sequencer_bench
